// ### src/decode_map.svh
// opcode group codes, field positions and counts for the instruction decoder
// assumes opcode byte 0 carries group and variant, byte 1 carries operand fields
`ifndef DECODE_MAP_SVH
`define DECODE_MAP_SVH

// group field and variant bits of the first opcode byte
`define GRP_MSB 7
`define GRP_LSB 3
`define VAR_ALT 0
`define VAR_FOUR 1
`define MAC_FUNC_MSB 2
`define MAC_FUNC_LSB 0

// operand byte fields
`define TRAP_MSB 6
`define TRAP_LSB 0
`define HOLD_MSB 5
`define HOLD_LSB 4
`define HOLD_BASE 3'h1

// group codes
`define GRP_ADD 5'h00
`define GRP_ADDC 5'h01
`define GRP_SUB 5'h02
`define GRP_SUBC 5'h03
`define GRP_MUL 5'h04
`define GRP_DIV 5'h05
`define GRP_CMPDEC 5'h06
`define GRP_CMPINC 5'h07
`define GRP_NORM 5'h08
`define GRP_SHRA 5'h09
`define GRP_WIDEN 5'h0a
`define GRP_JBIT1 5'h0b
`define GRP_JBIT0 5'h0c
`define GRP_BFIELD 5'h0d
`define GRP_BCOPY 5'h0e
`define GRP_PUSHCALL 5'h0f
`define GRP_CTXSW 5'h10
`define GRP_TRAP 5'h11
`define GRP_MAC 5'h12
`define GRP_WDOG 5'h13
`define GRP_EXTPAGE 5'h14
`define GRP_EXTSEG 5'h15
`define GRP_UNINT 5'h16
`define GRP_SLEEP 5'h17
`define GRP_NOP 5'h18

`endif

// ### src/decode_pkg.sv
// types shared by the instruction decoder and its bench
// assumes decode_map.svh supplies the numeric codes
package decode_pkg;

	typedef enum logic [4:0] {
		illegal_op,
		add_op,
		add_with_carry,
		sub_op,
		subtract_with_carry,
		multiply_op,
		short_divide_op,
		long_divide_op,
		compare_then_decrement,
		compare_then_increment,
		normalize_shift_count,
		sign_fill_right_shift,
		byte_widen_move,
		jump_on_bit_one,
		jump_on_bit_zero,
		masked_byte_field_modify,
		bit_copy,
		push_and_call,
		context_switch,
		soft_trap_op,
		mac_op,
		watchdog_on_off,
		extended_page_sequence,
		extended_segment_sequence,
		uninterruptible_sequence,
		legacy_sleep_opcode,
		null_op
	} op_class_t;

	typedef struct packed {
		op_class_t cls;
		logic four_byte;
		logic byte_op;
		logic use_carry;
		logic is_unsigned;
		logic step_two;
		logic count_up;
		logic zero_ext;
		logic sign_fill;
		logic bit_write;
		logic bit_value;
		logic invert;
		logic high_byte;
		logic push_first;
		logic reg_ext;
		logic wdt_enable;
		logic no_effect;
		logic [2:0] mac_func;
		logic [6:0] trap_num;
	} dec_t;

endpackage : decode_pkg

// ### src/cpu_instruction_decode.sv
// instruction decoder: class, length and variant fields of each fetched opcode
// assumes fetch presents both leading bytes with a one-cycle valid on sys_clk_in
`include "decode_map.svh"

// What this block does
// - multiply of two registers, signed or unsigned, two bytes long
// - short divide of low product half by a register, two bytes
// - long divide of full product register by a register, two bytes
// - compare then decrement register by one or two, two or four bytes
// - compare then increment register by one or two
// - normalisation count of one register written into another register
// - arithmetic right shift fills with sign bit, two bytes
// - byte to word move with sign or zero extension, two or four bytes
// - jump if bit one, optional clear of the bit, four bytes
// - jump if bit zero, optional set of the bit, four bytes
// - masked modify of high or low byte with immediate data, four bytes
// - copy bit to bit, optionally inverted, four bytes
// - push register then call absolute subroutine, four bytes
// - push register then load it with a word operand, four bytes
// - software trap with immediate trap number, two bytes
// - add and subtract, with or without carry, word or byte, two or four bytes
// - every multiply-accumulate coprocessor operation is four bytes
// - watchdog disable and enable opcodes, four bytes
// - extended page or segment sequences, optional register switch, two or four bytes
// - legacy sleep opcode decodes as legal but does nothing
module cpu_instruction_decode (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// fetch side
	input wire logic op_valid_in,
	input wire logic [7:0] op_byte0_in,
	input wire logic [7:0] op_byte1_in,
	// execute side
	output logic dec_valid_out,
	output decode_pkg::dec_t dec_out,
	output logic len_four_out,
	output logic irq_hold_out
);

	function automatic decode_pkg::op_class_t group_class(input logic [4:0] g,
		input logic long_v);
		case (g)
			`GRP_ADD: group_class = decode_pkg::add_op;
			`GRP_ADDC: group_class = decode_pkg::add_with_carry;
			`GRP_SUB: group_class = decode_pkg::sub_op;
			`GRP_SUBC: group_class = decode_pkg::subtract_with_carry;
			`GRP_MUL: group_class = decode_pkg::multiply_op;
			`GRP_DIV: group_class = long_v ? decode_pkg::long_divide_op :
				decode_pkg::short_divide_op;
			`GRP_CMPDEC: group_class = decode_pkg::compare_then_decrement;
			`GRP_CMPINC: group_class = decode_pkg::compare_then_increment;
			`GRP_NORM: group_class = decode_pkg::normalize_shift_count;
			`GRP_SHRA: group_class = decode_pkg::sign_fill_right_shift;
			`GRP_WIDEN: group_class = decode_pkg::byte_widen_move;
			`GRP_JBIT1: group_class = decode_pkg::jump_on_bit_one;
			`GRP_JBIT0: group_class = decode_pkg::jump_on_bit_zero;
			`GRP_BFIELD: group_class = decode_pkg::masked_byte_field_modify;
			`GRP_BCOPY: group_class = decode_pkg::bit_copy;
			`GRP_PUSHCALL: group_class = decode_pkg::push_and_call;
			`GRP_CTXSW: group_class = decode_pkg::context_switch;
			`GRP_TRAP: group_class = decode_pkg::soft_trap_op;
			`GRP_MAC: group_class = decode_pkg::mac_op;
			`GRP_WDOG: group_class = decode_pkg::watchdog_on_off;
			`GRP_EXTPAGE: group_class = decode_pkg::extended_page_sequence;
			`GRP_EXTSEG: group_class = decode_pkg::extended_segment_sequence;
			`GRP_UNINT: group_class = decode_pkg::uninterruptible_sequence;
			`GRP_SLEEP: group_class = decode_pkg::legacy_sleep_opcode;
			`GRP_NOP: group_class = decode_pkg::null_op;
			default: group_class = decode_pkg::illegal_op;
		endcase
	endfunction : group_class

	// opcode fields
	wire logic [4:0] grp = op_byte0_in[`GRP_MSB:`GRP_LSB];
	wire logic alt = op_byte0_in[`VAR_ALT];
	wire logic four_v = op_byte0_in[`VAR_FOUR];
	wire logic [2:0] mac_field = op_byte0_in[`MAC_FUNC_MSB:`MAC_FUNC_LSB];
	wire logic [6:0] trap_field = op_byte1_in[`TRAP_MSB:`TRAP_LSB];
	decode_pkg::op_class_t cls_w;
	assign cls_w = group_class(grp, four_v);

	// length selection
	wire logic fixed_four = cls_w inside {decode_pkg::jump_on_bit_one,
		decode_pkg::jump_on_bit_zero, decode_pkg::masked_byte_field_modify,
		decode_pkg::bit_copy, decode_pkg::push_and_call, decode_pkg::context_switch,
		decode_pkg::mac_op, decode_pkg::watchdog_on_off,
		decode_pkg::legacy_sleep_opcode};
	wire logic var_len = cls_w inside {decode_pkg::add_op, decode_pkg::add_with_carry,
		decode_pkg::sub_op, decode_pkg::subtract_with_carry,
		decode_pkg::compare_then_decrement, decode_pkg::compare_then_increment,
		decode_pkg::byte_widen_move, decode_pkg::extended_page_sequence,
		decode_pkg::extended_segment_sequence};
	wire logic four_w = fixed_four | (var_len & four_v);

	// class groupings
	wire logic is_arith = cls_w inside {decode_pkg::add_op, decode_pkg::add_with_carry,
		decode_pkg::sub_op, decode_pkg::subtract_with_carry};
	wire logic is_carry = cls_w inside {decode_pkg::add_with_carry,
		decode_pkg::subtract_with_carry};
	wire logic is_div = cls_w inside {decode_pkg::short_divide_op,
		decode_pkg::long_divide_op};
	wire logic is_step = cls_w inside {decode_pkg::compare_then_decrement,
		decode_pkg::compare_then_increment};
	wire logic is_jbit = cls_w inside {decode_pkg::jump_on_bit_one,
		decode_pkg::jump_on_bit_zero};
	wire logic is_ext = cls_w inside {decode_pkg::extended_page_sequence,
		decode_pkg::extended_segment_sequence};
	wire logic is_push = cls_w inside {decode_pkg::push_and_call,
		decode_pkg::context_switch};
	wire logic seq_open = op_valid_in & (is_ext |
		(cls_w == decode_pkg::uninterruptible_sequence));

	// decoded word
	decode_pkg::dec_t dec_w;
	assign dec_w.cls = cls_w;
	assign dec_w.four_byte = four_w;
	assign dec_w.byte_op = is_arith & alt;
	assign dec_w.use_carry = is_carry;
	assign dec_w.is_unsigned = ((cls_w == decode_pkg::multiply_op) | is_div) & alt;
	assign dec_w.step_two = is_step & alt;
	assign dec_w.count_up = cls_w == decode_pkg::compare_then_increment;
	assign dec_w.zero_ext = (cls_w == decode_pkg::byte_widen_move) & alt;
	assign dec_w.sign_fill = cls_w == decode_pkg::sign_fill_right_shift;
	assign dec_w.bit_write = is_jbit & alt;
	assign dec_w.bit_value = cls_w == decode_pkg::jump_on_bit_zero;
	assign dec_w.invert = (cls_w == decode_pkg::bit_copy) & alt;
	assign dec_w.high_byte = (cls_w == decode_pkg::masked_byte_field_modify) & alt;
	assign dec_w.push_first = is_push;
	assign dec_w.reg_ext = is_ext & alt;
	assign dec_w.wdt_enable = (cls_w == decode_pkg::watchdog_on_off) & alt;
	assign dec_w.no_effect = cls_w == decode_pkg::legacy_sleep_opcode;
	assign dec_w.mac_func = (cls_w == decode_pkg::mac_op) ?
		mac_field : 3'h0;
	assign dec_w.trap_num = (cls_w == decode_pkg::soft_trap_op) ?
		trap_field : 7'h00;

	// interrupt hold-off over covered instructions
	logic [2:0] hold_cnt_reg;
	logic [2:0] hold_cnt_next;
	wire logic [2:0] hold_len = {1'b0, op_byte1_in[`HOLD_MSB:`HOLD_LSB]} + `HOLD_BASE;
	wire logic hold_step = op_valid_in & (hold_cnt_reg != 3'h0);
	assign hold_cnt_next = seq_open ? hold_len :
		(hold_step ? hold_cnt_reg - 3'h1 : hold_cnt_reg);

	// output registers
	logic dec_valid_reg;
	decode_pkg::dec_t dec_reg;
	logic len_four_reg;
	logic irq_hold_reg;

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dec_valid_reg <= 1'b0;
			dec_reg <= '0;
			len_four_reg <= 1'b0;
			hold_cnt_reg <= 3'h0;
			irq_hold_reg <= 1'b0;
		end else begin
			dec_valid_reg <= op_valid_in;
			dec_reg <= op_valid_in ? dec_w : dec_reg;
			len_four_reg <= op_valid_in ? four_w : len_four_reg;
			hold_cnt_reg <= hold_cnt_next;
			irq_hold_reg <= hold_cnt_next != 3'h0;
		end
	end

	assign dec_valid_out = dec_valid_reg;
	assign dec_out = dec_reg;
	assign len_four_out = len_four_reg;
	assign irq_hold_out = irq_hold_reg;

	// checks
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	AST_MUL_FORM: assert property (
		op_valid_in && grp == `GRP_MUL |=> dec_valid_out && !len_four_out &&
		dec_out.cls == decode_pkg::multiply_op && dec_out.is_unsigned == $past(alt))
		else $error("multiply decode wrong");
	AST_SHORT_DIV: assert property (
		op_valid_in && grp == `GRP_DIV && !four_v |=> !len_four_out &&
		dec_out.cls == decode_pkg::short_divide_op)
		else $error("short divide decode wrong");
	AST_LONG_DIV: assert property (
		op_valid_in && grp == `GRP_DIV && four_v |=> !len_four_out &&
		dec_out.cls == decode_pkg::long_divide_op)
		else $error("long divide decode wrong");
	AST_CMP_DEC: assert property (
		op_valid_in && grp == `GRP_CMPDEC |=> !dec_out.count_up &&
		len_four_out == $past(four_v) && dec_out.step_two == $past(alt))
		else $error("compare-decrement decode wrong");
	AST_CMP_INC: assert property (
		op_valid_in && grp == `GRP_CMPINC |=> dec_out.count_up &&
		dec_out.step_two == $past(alt))
		else $error("compare-increment decode wrong");
	AST_SIGN_FILL: assert property (
		dec_valid_out && dec_out.cls == decode_pkg::sign_fill_right_shift |->
		dec_out.sign_fill && !len_four_out)
		else $error("arithmetic shift decode wrong");
	AST_WIDEN: assert property (
		op_valid_in && grp == `GRP_WIDEN |=> dec_out.zero_ext == $past(alt) &&
		len_four_out == $past(four_v))
		else $error("widen move decode wrong");
	AST_JBIT: assert property (
		op_valid_in && grp == `GRP_JBIT1 |=> len_four_out && !dec_out.bit_value &&
		dec_out.bit_write == $past(alt))
		else $error("bit-one jump decode wrong");
	AST_PUSH_FOUR: assert property (
		dec_valid_out && dec_out.push_first |-> len_four_out)
		else $error("push form not four bytes");
	AST_MAC_FOUR: assert property (
		dec_valid_out && dec_out.cls == decode_pkg::mac_op |-> len_four_out)
		else $error("coprocessor op not four bytes");
	AST_SLEEP_LEGAL: assert property (
		op_valid_in && grp == `GRP_SLEEP |=> dec_out.cls != decode_pkg::illegal_op &&
		dec_out.no_effect)
		else $error("sleep opcode decode wrong");
	AST_LEN_MATCH: assert property (
		dec_valid_out |-> len_four_out == dec_out.four_byte)
		else $error("length output mismatch");
	AST_HOLD_SPAN: assert property (
		seq_open |=> irq_hold_out && hold_cnt_reg == $past(hold_len))
		else $error("interrupt hold not started");
	AST_HOLD_END: assert property (
		hold_cnt_reg == 3'h1 && op_valid_in && !seq_open |=> !irq_hold_out)
		else $error("interrupt hold not released");

	// per-group field checks
	AST_SHORT_DIV_SIGN: assert property (
		op_valid_in && grp == `GRP_DIV && !four_v |=> dec_valid_out &&
		dec_out.is_unsigned == $past(alt))
		else $error("short divide signedness wrong");
	AST_LONG_DIV_SIGN: assert property (
		op_valid_in && grp == `GRP_DIV && four_v |=> dec_valid_out &&
		dec_out.is_unsigned == $past(alt))
		else $error("long divide signedness wrong");
	AST_NORM_FORM: assert property (
		op_valid_in && grp == `GRP_NORM |=> !len_four_out &&
		dec_out.cls == decode_pkg::normalize_shift_count)
		else $error("normalise count decode wrong");
	AST_SHRA_FORM: assert property (
		op_valid_in && grp == `GRP_SHRA |=> dec_out.sign_fill && !len_four_out &&
		dec_out.cls == decode_pkg::sign_fill_right_shift)
		else $error("sign fill shift decode wrong");
	AST_JBIT_ZERO: assert property (
		op_valid_in && grp == `GRP_JBIT0 |=> len_four_out && dec_out.bit_value &&
		dec_out.bit_write == $past(alt))
		else $error("bit-zero jump decode wrong");
	AST_BFIELD_FORM: assert property (
		op_valid_in && grp == `GRP_BFIELD |=> len_four_out &&
		dec_out.high_byte == $past(alt))
		else $error("masked field decode wrong");
	AST_BCOPY_FORM: assert property (
		op_valid_in && grp == `GRP_BCOPY |=> len_four_out &&
		dec_out.invert == $past(alt))
		else $error("bit copy decode wrong");
	AST_CTXSW_FORM: assert property (
		op_valid_in && grp == `GRP_CTXSW |=> len_four_out && dec_out.push_first &&
		dec_out.cls == decode_pkg::context_switch)
		else $error("context switch decode wrong");
	AST_TRAP_FORM: assert property (
		op_valid_in && grp == `GRP_TRAP |=> !len_four_out &&
		dec_out.trap_num == $past(trap_field))
		else $error("trap decode wrong");
	AST_ADD_SUB: assert property (
		op_valid_in && (grp == `GRP_ADD || grp == `GRP_SUB) |=> !dec_out.use_carry &&
		dec_out.byte_op == $past(alt) && len_four_out == $past(four_v))
		else $error("plain add or subtract decode wrong");
	AST_CARRY_FORM: assert property (
		op_valid_in && (grp == `GRP_ADDC || grp == `GRP_SUBC) |=> dec_out.use_carry &&
		dec_out.byte_op == $past(alt) && len_four_out == $past(four_v))
		else $error("carry add or subtract decode wrong");
	AST_MAC_FORM: assert property (
		op_valid_in && grp == `GRP_MAC |=> len_four_out &&
		dec_out.mac_func == $past(mac_field))
		else $error("coprocessor decode wrong");
	AST_WDOG_FORM: assert property (
		op_valid_in && grp == `GRP_WDOG |=> len_four_out &&
		dec_out.wdt_enable == $past(alt))
		else $error("watchdog decode wrong");
	AST_EXT_FORM: assert property (
		op_valid_in && (grp == `GRP_EXTPAGE || grp == `GRP_EXTSEG) |=>
		dec_out.reg_ext == $past(alt) && len_four_out == $past(four_v))
		else $error("extended sequence decode wrong");
	AST_ILLEGAL_SHORT: assert property (
		op_valid_in && grp > `GRP_NOP |=> !len_four_out &&
		dec_out.cls == decode_pkg::illegal_op)
		else $error("unknown group decode wrong");

	// handshake and hold-off timing checks
	AST_VALID_FOLLOW: assert property (
		dec_valid_out == $past(op_valid_in))
		else $error("decode valid not one cycle after offer");
	AST_OUT_HOLD: assert property (
		!op_valid_in |=> $stable(dec_out) && $stable(len_four_out))
		else $error("decode output moved without an offer");
	AST_HOLD_KEEP: assert property (
		!op_valid_in |=> $stable(hold_cnt_reg) && $stable(irq_hold_out))
		else $error("hold count moved without an instruction");
	AST_HOLD_STEP: assert property (
		hold_cnt_reg > 3'h1 && op_valid_in && !seq_open |=> irq_hold_out &&
		hold_cnt_reg == $past(hold_cnt_reg) - 3'h1)
		else $error("hold count did not step");

endmodule : cpu_instruction_decode

// ### bench/fetch_model.sv
// fetch side model: offers opcodes to the decoder
// assumes the caller orders send and idle calls
module fetch_model (
	// clock
	input wire logic sys_clk_in,
	// opcode offer
	output logic op_valid_out,
	output logic [7:0] op_byte0_out,
	output logic [7:0] op_byte1_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		op_valid_out = 1'b0;
		op_byte0_out = 8'h00;
		op_byte1_out = 8'h00;
	end

	// offer taken at the following edge
	task automatic send(input logic [7:0] b0, input logic [7:0] b1);
		@(posedge sys_clk_in);
		op_valid_out <= 1'b1;
		op_byte0_out <= b0;
		op_byte1_out <= b1;
	endtask : send

	// no offer, stale bytes scrambled
	task automatic idle();
		@(posedge sys_clk_in);
		op_valid_out <= 1'b0;
		op_byte0_out <= ~op_byte0_out;
		op_byte1_out <= ~op_byte1_out;
	endtask : idle
endmodule : fetch_model

// ### bench/cpu_instruction_decode_test.sv
// self-checking bench for the instruction decoder
// assumes fetch_model stands in for the fetch unit
`include "decode_map.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end

module cpu_instruction_decode_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in;
	logic reset_n_in;
	logic op_valid_in;
	logic [7:0] op_byte0_in;
	logic [7:0] op_byte1_in;
	logic dec_valid_out;
	decode_pkg::dec_t dec_out;
	logic len_four_out;
	logic irq_hold_out;
	int failures = 0;
	int n_checks = 0;

	fetch_model FETCH (.sys_clk_in(sys_clk_in), .op_valid_out(op_valid_in),
		.op_byte0_out(op_byte0_in), .op_byte1_out(op_byte1_in));
	cpu_instruction_decode DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.op_valid_in(op_valid_in), .op_byte0_in(op_byte0_in), .op_byte1_in(op_byte1_in),
		.dec_valid_out(dec_valid_out), .dec_out(dec_out), .len_four_out(len_four_out),
		.irq_hold_out(irq_hold_out));

	function automatic decode_pkg::op_class_t exp_cls(input logic [4:0] g, input logic lng);
		if (g > 5'h18) return decode_pkg::illegal_op;
		if (g < 5'h05) return decode_pkg::op_class_t'(g + 5'h01);
		if (g == `GRP_DIV) return lng ? decode_pkg::long_divide_op : decode_pkg::short_divide_op;
		return decode_pkg::op_class_t'(g + 5'h02);
	endfunction : exp_cls

	function automatic logic exp_len(input logic [4:0] g, input logic b1);
		case (g)
			`GRP_MUL, `GRP_DIV, `GRP_NORM, `GRP_SHRA, `GRP_TRAP, `GRP_UNINT, `GRP_NOP: return 1'b0;
			`GRP_JBIT1, `GRP_JBIT0, `GRP_BFIELD, `GRP_BCOPY, `GRP_PUSHCALL, `GRP_CTXSW,
			`GRP_MAC, `GRP_WDOG, `GRP_SLEEP: return 1'b1;
			default: return (g > 5'h18) ? 1'b0 : b1;
		endcase
	endfunction : exp_len

	// one opcode, answer one cycle later
	task automatic dec(input logic [7:0] b0, input logic [7:0] b1);
		FETCH.send(b0, b1);
		FETCH.idle();
		#1;
		`CHK(dec_valid_out, 1'b1)
	endtask : dec

	// every group with every variant bit pair
	task automatic t_all();
		logic [4:0] g;
		logic a;
		for (int i = 0; i < 26; i++) begin
			for (int j = 0; j < 4; j++) begin
				g = (i == 25) ? 5'h1f : 5'(i);
				a = j[0];
				dec({g, j[1], j[1:0]}, 8'h4a);
				`CHK(dec_out.cls, exp_cls(g, j[1]))
				`CHK(len_four_out, exp_len(g, j[1]))
				case (g)
					`GRP_ADD, `GRP_SUB: `CHK({dec_out.use_carry, dec_out.byte_op}, {1'b0, a})
					`GRP_ADDC, `GRP_SUBC: `CHK({dec_out.use_carry, dec_out.byte_op}, {1'b1, a})
					`GRP_MUL, `GRP_DIV: `CHK(dec_out.is_unsigned, a)
					`GRP_CMPDEC, `GRP_CMPINC: `CHK({dec_out.count_up, dec_out.step_two},
						{g == `GRP_CMPINC, a})
					`GRP_NORM: `CHK(len_four_out, 1'b0)
					`GRP_SHRA: `CHK(dec_out.sign_fill, 1'b1)
					`GRP_WIDEN: `CHK(dec_out.zero_ext, a)
					`GRP_JBIT1, `GRP_JBIT0: `CHK({dec_out.bit_write, dec_out.bit_value},
						{a, g == `GRP_JBIT0})
					`GRP_BFIELD: `CHK(dec_out.high_byte, a)
					`GRP_BCOPY: `CHK(dec_out.invert, a)
					`GRP_PUSHCALL, `GRP_CTXSW: `CHK(dec_out.push_first, 1'b1)
					`GRP_TRAP: `CHK(dec_out.trap_num, 7'h4a)
					`GRP_MAC: `CHK(dec_out.mac_func, {j[1], j[1:0]})
					`GRP_WDOG: `CHK(dec_out.wdt_enable, a)
					`GRP_EXTPAGE, `GRP_EXTSEG: `CHK(dec_out.reg_ext, a)
					`GRP_SLEEP: `CHK(dec_out.no_effect, 1'b1)
					default: ;
				endcase
			end
		end
		$display("t_all finished");
	endtask : t_all

	// hold-off over covered count, reload by a new opener
	task automatic t_hold();
		dec({`GRP_EXTPAGE, 3'h0}, 8'h30);
		`CHK(irq_hold_out, 1'b1)
		repeat (3) begin
			dec({`GRP_NOP, 3'h0}, 8'h00);
			`CHK(irq_hold_out, 1'b1)
		end
		dec({`GRP_NOP, 3'h0}, 8'h00);
		`CHK(irq_hold_out, 1'b0)
		dec({`GRP_EXTSEG, 3'h2}, 8'h10);
		dec({`GRP_NOP, 3'h0}, 8'h00);
		`CHK(irq_hold_out, 1'b1)
		dec({`GRP_UNINT, 3'h0}, 8'h00);
		`CHK(irq_hold_out, 1'b1)
		dec({`GRP_NOP, 3'h0}, 8'h00);
		`CHK(irq_hold_out, 1'b0)
		$display("t_hold finished");
	endtask : t_hold

	// two opcodes on consecutive edges
	task automatic t_b2b();
		FETCH.send({`GRP_MUL, 3'h1}, 8'h00);
		FETCH.send({`GRP_ADD, 3'h2}, 8'h00);
		#1;
		`CHK({dec_valid_out, dec_out.is_unsigned}, 2'h3)
		FETCH.idle();
		#1;
		`CHK({dec_valid_out, len_four_out, dec_out.cls}, {2'h3, decode_pkg::add_op})
		FETCH.idle();
		#1;
		`CHK({dec_valid_out, dec_out.cls}, {1'b0, decode_pkg::add_op})
		$display("t_b2b finished");
	endtask : t_b2b

	// reset in the middle of a hold-off
	task automatic t_reset_mid();
		dec({`GRP_EXTPAGE, 3'h0}, 8'h30);
		@(posedge sys_clk_in);
		reset_n_in <= 1'b0;
		@(posedge sys_clk_in);
		#1;
		`CHK({dec_valid_out, dec_out, irq_hold_out, len_four_out}, '0)
		@(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		dec({`GRP_NOP, 3'h0}, 8'h00);
		`CHK(irq_hold_out, 1'b0)
		$display("t_reset_mid finished");
	endtask : t_reset_mid

	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	initial begin
		reset_n_in = 1'b0;
		repeat (12) @(posedge sys_clk_in);
		#1;
		`CHK({dec_valid_out, dec_out, irq_hold_out, len_four_out}, '0)
		@(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		t_all();
		t_hold();
		t_b2b();
		t_reset_mid();
		test_done();
	end
endmodule : cpu_instruction_decode_test
